// File: src/wsru_pkg.sv
`default_nettype none
package wsru_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_CMD   = 8'h00; // write starts an operation
    localparam logic [7:0] ADR_CTRL  = 8'h04; // reversible shift control word
    localparam logic [7:0] ADR_RANGE = 8'h08; // first index low, last high
    localparam logic [7:0] ADR_SRC   = 8'h0C; // word shift source word
    localparam logic [7:0] ADR_OPND  = 8'h10; // single-word operand and result
    localparam logic [7:0] ADR_FLAGS = 8'h14; // error, carry, zero, negative, busy
    localparam logic [7:0] ADR_ISTAT = 8'h18; // sticky events, write one to clear
    localparam logic [7:0] ADR_IMASK = 8'h1C; // interrupt enables
    localparam logic [1:0] MEM_PAGE  = 2'h1;  // word range at 0x40 upward
    localparam int RANGE_LAST_LSB = 8;
    // opcodes
    localparam logic [6:0] OP_WORD_SHIFT_OP  = 7'h10; // 016
    localparam logic [6:0] OP_ASL   = 7'h19; // 025
    localparam logic [6:0] OP_ASR   = 7'h1A; // 026
    localparam logic [6:0] OP_ROL   = 7'h1B; // 027
    localparam logic [6:0] OP_ROR   = 7'h1C; // 028
    localparam logic [6:0] OP_DIGL  = 7'h4A; // 074
    localparam logic [6:0] OP_DIGR  = 7'h4B; // 075
    localparam logic [6:0] OP_REVERSIBLE_SHIFT_OP  = 7'h54; // 084
    // control word bits
    localparam int CB_RST = 15;
    localparam int CB_STB = 14;
    localparam int CB_SIN = 13;
    localparam int CB_DIR = 12;
    // flag and event bits
    localparam int F_ERR  = 0;
    localparam int F_CY   = 1;
    localparam int F_ZERO = 2;
    localparam int F_NEG  = 3;
    localparam int F_BUSY = 4;
    localparam int I_DONE = 0;
    localparam int I_ERR  = 1;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0]  RST_IRQ  = 2'h0;
    // per-word step kinds
    typedef enum logic [5:0] {
        M_BITL = 6'h01,
        M_BITR = 6'h02,
        M_WORD = 6'h04,
        M_DIGL = 6'h08,
        M_DIGR = 6'h10,
        M_CLR  = 6'h20
    } wsru_mode_t;
    // sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_RUN  = 3'h2,
        S_FIN  = 3'h4
    } wsru_state_t;
endpackage : wsru_pkg
`default_nettype wire

// File: src/wsru_step.sv
`default_nettype none
// one word of a multi-word shift: hold carries what leaves this word
module wsru_step (
    input  wire logic              [5:0]  mode_i,
    input  wire logic              [15:0] word_i,
    input  wire logic              [15:0] hold_i,
    output logic                   [15:0] word_o,
    output logic                   [15:0] hold_o
);
    // pick the new word and the outgoing bits by step kind
    always_comb begin
        word_o = word_i;
        hold_o = hold_i;
        case (mode_i)
            wsru_pkg::M_BITL: begin
                word_o = {word_i[14:0], hold_i[0]};
                hold_o = {15'h0, word_i[15]};
            end
            wsru_pkg::M_BITR: begin
                word_o = {hold_i[0], word_i[15:1]};
                hold_o = {15'h0, word_i[0]};
            end
            wsru_pkg::M_WORD: begin
                word_o = hold_i;
                hold_o = word_i;
            end
            wsru_pkg::M_DIGL: begin
                word_o = {word_i[11:0], hold_i[3:0]};
                hold_o = {12'h000, word_i[15:12]};
            end
            wsru_pkg::M_DIGR: begin
                word_o = {hold_i[3:0], word_i[15:4]};
                hold_o = {12'h000, word_i[3:0]};
            end
            wsru_pkg::M_CLR: begin
                word_o = 16'h0000;
                hold_o = 16'h0000;
            end
            default: begin
                word_o = word_i;
                hold_o = hold_i;
            end
        endcase
    end
endmodule : wsru_step
`default_nettype wire

// File: src/wsru_core.sv
// Chosen here: the Wishbone register port and the register addresses.
`default_nettype none
// shift and rotate unit behind a classic wishbone slave
module wsru_core #(
    parameter int DEPTH = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             done_o,
    output logic             busy_o
);
    localparam int IDXW = $clog2(DEPTH);
    // index fields keep only the low IDXW bits, so a range
    // beyond DEPTH wraps instead of reaching past the array;
    // software must keep first and last inside the window

    // state
    logic [15:0]           mem [DEPTH];  // the word range
    logic [15:0]           ctrl;         // control word
    logic [IDXW-1:0]       first_idx;    // first word of range
    logic [IDXW-1:0]       last_idx;     // last word of range
    logic [15:0]           src;          // word shift source
    logic [15:0]           opnd;         // single-word operand
    logic                  f_err;        // error flag
    logic                  f_cy;         // carry flag
    logic                  f_zero;       // zero flag
    logic                  f_neg;        // negative flag
    logic                  prev_stb;     // strobe seen at last 084
    logic [1:0]            istat;        // sticky events
    logic [1:0]            imask;        // event enables
    wsru_pkg::wsru_state_t state;        // sequencer state
    wsru_pkg::wsru_mode_t  mode;         // step kind of running op
    logic [IDXW-1:0]       ptr;          // word being processed
    logic [IDXW-1:0]       end_ptr;      // last word to process
    logic [15:0]           hold;         // bits travelling between words

    // every access is acked once, mapped or not, so a stray
    // address never stalls the master; writes to operands
    // are dropped while busy rather than held off
    // bus decode
    logic            bus_req;   // request present
    logic            bus_wr;    // write takes effect this edge
    logic            idle;      // sequencer idle
    logic            idle_wr;   // write allowed to operands
    logic [15:0]     wm;        // byte lane mask, low half
    logic [IDXW-1:0] bus_idx;   // word index of range access
    logic            is_mem;    // address hits the range window
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr  = bus_req & wb_we_i & wb_ack_o;
    assign idle    = state == wsru_pkg::S_IDLE;
    assign idle_wr = bus_wr & idle;
    assign wm      = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign bus_idx = wb_adr_i[2 +: IDXW];
    assign is_mem  = (wb_adr_i[7:6] == wsru_pkg::MEM_PAGE) && (32'(wb_adr_i[5:2]) < DEPTH);

    logic hit_cmd, hit_ctrl, hit_rng, hit_src, hit_opnd, hit_flg, hit_ist, hit_imk, hit_mem;
    assign hit_cmd  = idle_wr & (wb_adr_i == wsru_pkg::ADR_CMD) & wb_sel_i[0];
    assign hit_ctrl = idle_wr & (wb_adr_i == wsru_pkg::ADR_CTRL);
    assign hit_rng  = idle_wr & (wb_adr_i == wsru_pkg::ADR_RANGE);
    assign hit_src  = idle_wr & (wb_adr_i == wsru_pkg::ADR_SRC);
    assign hit_opnd = idle_wr & (wb_adr_i == wsru_pkg::ADR_OPND);
    assign hit_flg  = idle_wr & (wb_adr_i == wsru_pkg::ADR_FLAGS) & wb_sel_i[0];
    assign hit_ist  = bus_wr & (wb_adr_i == wsru_pkg::ADR_ISTAT) & wb_sel_i[0];
    assign hit_imk  = bus_wr & (wb_adr_i == wsru_pkg::ADR_IMASK) & wb_sel_i[0];
    assign hit_mem  = idle_wr & is_mem;

    // the opcode is taken straight off the write data: it only
    // matters in the one cycle that the command write lands
    // opcode decode on the start write
    logic [6:0] opc;        // opcode written
    logic       is_single;  // one-word shift or rotate
    logic       is_multi;   // range operation
    logic       is_reversible_shift_op;    // reversible shift
    logic       start;      // operation accepted
    logic       range_err;  // first above last
    logic       reversible_shift_op_edge;  // strobe turned on since last 084
    logic       run_go;     // range will actually be walked
    assign opc       = wb_dat_i[6:0];
    assign is_reversible_shift_op   = opc == wsru_pkg::OP_REVERSIBLE_SHIFT_OP;
    assign is_single = (opc == wsru_pkg::OP_ASL) | (opc == wsru_pkg::OP_ASR) |
                       (opc == wsru_pkg::OP_ROL) | (opc == wsru_pkg::OP_ROR);
    assign is_multi  = is_reversible_shift_op | (opc == wsru_pkg::OP_WORD_SHIFT_OP) |
                       (opc == wsru_pkg::OP_DIGL) | (opc == wsru_pkg::OP_DIGR);
    assign start     = hit_cmd;
    assign range_err = first_idx > last_idx;
    assign reversible_shift_op_edge = ctrl[wsru_pkg::CB_STB] & ~prev_stb;
    // reset outranks the strobe: no edge needed to clear
    assign run_go    = start & is_multi & ~range_err &
                       (~is_reversible_shift_op | ctrl[wsru_pkg::CB_RST] | reversible_shift_op_edge);

    // reset is checked before direction so a set reset bit
    // always clears, whatever the strobe and direction say
    // step kind chosen at start
    wsru_pkg::wsru_mode_t next_mode;
    logic                 desc;      // walk from last word down
    logic [15:0]          hold_init; // what enters the range
    assign next_mode = (opc == wsru_pkg::OP_WORD_SHIFT_OP) ? wsru_pkg::M_WORD :
                       (opc == wsru_pkg::OP_DIGL) ? wsru_pkg::M_DIGL :
                       (opc == wsru_pkg::OP_DIGR) ? wsru_pkg::M_DIGR :
                       ctrl[wsru_pkg::CB_RST]     ? wsru_pkg::M_CLR  :
                       ctrl[wsru_pkg::CB_DIR]     ? wsru_pkg::M_BITR :
                                                    wsru_pkg::M_BITL;
    assign desc      = (next_mode == wsru_pkg::M_BITR) | (next_mode == wsru_pkg::M_DIGR);
    // digit shifts fill with zero, word shift loads the source
    assign hold_init = (next_mode == wsru_pkg::M_WORD) ? src :
                       ((next_mode == wsru_pkg::M_BITL) | (next_mode == wsru_pkg::M_BITR)) ?
                       {15'h0, ctrl[wsru_pkg::CB_SIN]} : 16'h0000;

    // one word per cycle: slower than a wide shifter, but
    // the cost stays one word of logic for any depth
    // per-word step
    logic [15:0] step_word; // new value of word at ptr
    logic [15:0] step_hold; // bits leaving that word
    logic        at_end;    // last word this cycle
    logic        bit_mode;  // mode that reports carry
    logic        up;        // running op walks upward
    wsru_step u_step (
        .mode_i (mode),
        .word_i (mem[ptr]),
        .hold_i (hold),
        .word_o (step_word),
        .hold_o (step_hold)
    );
    assign at_end   = (state == wsru_pkg::S_RUN) && (ptr == end_ptr);
    assign bit_mode = (mode == wsru_pkg::M_BITL) | (mode == wsru_pkg::M_BITR) |
                      (mode == wsru_pkg::M_CLR);
    assign up       = (mode != wsru_pkg::M_BITR) & (mode != wsru_pkg::M_DIGR);

    // single-word ops finish in the cycle of the command write;
    // the rotates read the carry flag as it stands, so software
    // may preset it through the flags register first
    // single-word datapath
    logic [15:0] sw_res;   // shifted or rotated operand
    logic        sw_cy;    // bit shifted out
    logic        opnd_msb; // operand bit 15
    logic        opnd_lsb; // operand bit 0
    assign opnd_msb = opnd[15];
    assign opnd_lsb = opnd[0];
    assign sw_res = (opc == wsru_pkg::OP_ASL) ? {opnd[14:0], 1'b0} :
                    (opc == wsru_pkg::OP_ASR) ? {1'b0, opnd[15:1]} :
                    (opc == wsru_pkg::OP_ROL) ? {opnd[14:0], f_cy} :
                                                {f_cy, opnd[15:1]};
    assign sw_cy  = ((opc == wsru_pkg::OP_ASL) | (opc == wsru_pkg::OP_ROL)) ? opnd_msb : opnd_lsb;

    // commands that walk nothing still pass through the
    // finish state so that every command gives one done pulse
    // next sequencer state
    wsru_pkg::wsru_state_t next_state;
    assign next_state = (idle & start)           ? (run_go ? wsru_pkg::S_RUN : wsru_pkg::S_FIN) :
                        (at_end)                 ? wsru_pkg::S_FIN :
                        (state == wsru_pkg::S_FIN) ? wsru_pkg::S_IDLE : state;

    // interrupt status: set wins over write-one-clear
    logic [1:0] ev;          // events this cycle
    logic [1:0] next_istat;  // status after set and clear
    assign ev[wsru_pkg::I_DONE] = state == wsru_pkg::S_FIN;
    assign ev[wsru_pkg::I_ERR]  = start & is_multi & range_err;
    assign next_istat = (istat & ~(hit_ist ? wb_dat_i[1:0] : 2'h0)) | ev;

    // reads are side-effect free; the status register is only
    // cleared by an explicit write of ones
    // read mux
    logic [31:0] rd;
    assign rd = (wb_adr_i == wsru_pkg::ADR_CTRL)  ? {16'h0000, ctrl} :
                (wb_adr_i == wsru_pkg::ADR_RANGE) ? 32'({last_idx, 8'(first_idx)}) << 0 :
                (wb_adr_i == wsru_pkg::ADR_SRC)   ? {16'h0000, src} :
                (wb_adr_i == wsru_pkg::ADR_OPND)  ? {16'h0000, opnd} :
                (wb_adr_i == wsru_pkg::ADR_FLAGS) ? {27'h0, busy_o, f_neg, f_zero, f_cy, f_err} :
                (wb_adr_i == wsru_pkg::ADR_ISTAT) ? {30'h0, istat} :
                (wb_adr_i == wsru_pkg::ADR_IMASK) ? {30'h0, imask} :
                is_mem                            ? {16'h0000, mem[bus_idx]} : 32'h0;

    // bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= rd;
        end
    end

    // operands may not move under a running walk, or the
    // end pointer and the source word would disagree
    // software registers; operands frozen while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= wsru_pkg::RST_WORD;
            src       <= wsru_pkg::RST_WORD;
            first_idx <= '0;
            last_idx  <= '0;
        end else begin
            if (hit_ctrl) ctrl <= (ctrl & ~wm) | (wb_dat_i[15:0] & wm);
            if (hit_src)  src <= (src & ~wm) | (wb_dat_i[15:0] & wm);
            if (hit_rng & wb_sel_i[0]) first_idx <= wb_dat_i[IDXW-1:0];
            if (hit_rng & wb_sel_i[1]) last_idx <= wb_dat_i[wsru_pkg::RANGE_LAST_LSB +: IDXW];
        end
    end

    // single-word operand and strobe history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opnd     <= wsru_pkg::RST_WORD;
            prev_stb <= 1'b0;
        end else begin
            if (start & is_single) opnd <= sw_res;
            else if (hit_opnd) opnd <= (opnd & ~wm) | (wb_dat_i[15:0] & wm);
            if (start & is_reversible_shift_op) prev_stb <= ctrl[wsru_pkg::CB_STB];
        end
    end

    // zero and negative belong to single-word ops only;
    // range ops leave them as software last saw them
    // flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {f_neg, f_zero, f_cy, f_err} <= 4'h0;
        end else if (start & is_single) begin
            f_err  <= 1'b0;
            f_cy   <= sw_cy;
            f_zero <= sw_res == 16'h0000;
            f_neg  <= sw_res[15];
        end else if (start & is_multi) begin
            f_err <= range_err;
        end else if (at_end & bit_mode) begin
            f_cy <= step_hold[0];
        end else if (hit_flg) begin
            {f_neg, f_zero, f_cy, f_err} <= wb_dat_i[3:0];
        end
    end

    // right-going modes start at the last word so the bit or
    // digit leaving each word is ready for its lower neighbour
    // sequencer: walks the range one word per cycle, never interrupted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= wsru_pkg::S_IDLE;
            mode    <= wsru_pkg::M_BITL;
            ptr     <= '0;
            end_ptr <= '0;
            hold    <= 16'h0000;
        end else begin
            state <= next_state;
            if (idle & run_go) begin
                mode    <= next_mode;
                ptr     <= desc ? last_idx : first_idx;
                end_ptr <= desc ? first_idx : last_idx;
                hold    <= hold_init;
            end else if (state == wsru_pkg::S_RUN) begin
                hold <= step_hold;
                ptr  <= up ? ptr + 1'b1 : ptr - 1'b1;
            end
        end
    end

    // bus writes to the range are gated by idle, so the two
    // writers can never meet on the same edge
    // word range: sequencer or software, never both
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) mem[i] <= wsru_pkg::RST_WORD;
        end else if (state == wsru_pkg::S_RUN) begin
            mem[ptr] <= step_word;
        end else if (hit_mem) begin
            mem[bus_idx] <= (mem[bus_idx] & ~wm) | (wb_dat_i[15:0] & wm);
        end
    end

    // interrupt, done pulse and busy level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat  <= wsru_pkg::RST_IRQ;
            imask  <= wsru_pkg::RST_IRQ;
            irq_o  <= 1'b0;
            done_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            istat  <= next_istat;
            if (hit_imk) imask <= wb_dat_i[1:0];
            irq_o  <= |(next_istat & imask);
            done_o <= state == wsru_pkg::S_FIN;
            busy_o <= next_state != wsru_pkg::S_IDLE;
        end
    end

    // each check looks one edge after the step it guards,
    // when the written word is visible in the array
    // checks
    clear_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        at_end && mode == wsru_pkg::M_CLR |=> !f_cy && mem[$past(ptr)] == 16'h0000)
        else $error("reset did not clear carry and word");
    left_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == wsru_pkg::S_RUN && mode == wsru_pkg::M_BITL && ptr == first_idx
        |=> mem[first_idx][0] == $past(hold[0]))
        else $error("serial bit missed bit 00");
    // right shift: serial bit lands on top of the last word
    right_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == wsru_pkg::S_RUN && mode == wsru_pkg::M_BITR && ptr == last_idx
        |=> mem[last_idx][15] == $past(hold[0]))
        else $error("serial bit missed bit 15");
    // word shift: source word lands in the first word
    word_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == wsru_pkg::S_RUN && mode == wsru_pkg::M_WORD && ptr == first_idx
        |=> mem[first_idx] == $past(src))
        else $error("source word not loaded");
    // digit left: lowest digit of the first word is zero
    digit_left_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == wsru_pkg::S_RUN && mode == wsru_pkg::M_DIGL && ptr == first_idx
        |=> mem[first_idx][3:0] == 4'h0)
        else $error("digit left fill not zero");
    // digit right: top digit of the last word is zero
    digit_right_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == wsru_pkg::S_RUN && mode == wsru_pkg::M_DIGR && ptr == last_idx
        |=> mem[last_idx][15:12] == 4'h0)
        else $error("digit right fill not zero");
    range_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && is_multi |=> f_err == $past(range_err) ##1 state != wsru_pkg::S_RUN || !f_err)
        else $error("error flag wrong for range");
    asl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && opc == wsru_pkg::OP_ASL |=> opnd == ($past(opnd) << 1) && f_cy == $past(opnd_msb))
        else $error("arith left wrong");
    asr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && opc == wsru_pkg::OP_ASR |=> !f_neg && opnd == ($past(opnd) >> 1) && f_cy == $past(opnd_lsb))
        else $error("arith right wrong");
    rol_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && opc == wsru_pkg::OP_ROL |=> opnd[0] == $past(f_cy) && f_cy == $past(opnd_msb))
        else $error("rotate left lost carry");
    ror_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && opc == wsru_pkg::OP_ROR |=> opnd[15] == $past(f_cy) && f_cy == $past(opnd_lsb))
        else $error("rotate right lost carry");
    zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && is_single |=> f_zero == (opnd == 16'h0000) && f_neg == opnd[15])
        else $error("zero or negative flag wrong");
    done_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
        at_end |=> state == wsru_pkg::S_FIN && busy_o ##1 done_o && !busy_o)
        else $error("done not after last word");
endmodule : wsru_core
`default_nettype wire

// File: test/wsru_seq_model.sv
`default_nettype none
// sequencer stand-in: classic wishbone master, one request at a time
module wsru_seq_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0000_0000;
    end
    // request held until ack; released data toggles so nothing stale looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 200);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : wsru_seq_model
`default_nettype wire

// File: test/test_word_shift_rotate_unit.sv
`default_nettype none
module test_word_shift_rotate_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq, done, busy;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    // single-word table: opcode, operand, flags in, result, flags out
    logic [6:0]  s_op [6] = '{wsru_pkg::OP_ASL, wsru_pkg::OP_ASL, wsru_pkg::OP_ASR,
                              wsru_pkg::OP_ROL, wsru_pkg::OP_ROR, wsru_pkg::OP_ROR};
    logic [15:0] s_in [6] = '{16'h8001, 16'h4000, 16'h8001, 16'h8000, 16'h0001, 16'h0000};
    logic [15:0] s_fi [6] = '{16'h0001, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0002};
    logic [15:0] s_rs [6] = '{16'h0002, 16'h8000, 16'h4000, 16'h0001, 16'h0000, 16'h8000};
    logic [31:0] s_fo [6] = '{32'h2, 32'h8, 32'h2, 32'h2, 32'h6, 32'h8};
    // free-running clock, 50 ns
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    wsru_core #(.DEPTH(16)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .done_o(done), .busy_o(busy));
    wsru_seq_model i_seq (
        .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .dat_o(wdat));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_seq.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        i_seq.xfer(1'b0, a, 16'h0000, v);
        check(what, v, exp);
    endtask : rc
    function automatic logic [7:0] wa(input int i);
        return 8'h40 + 8'(4 * i); // range word i
    endfunction : wa
    // start a command and wait, bounded, for its done pulse
    task automatic run(input logic [6:0] op);
        int n;
        n = 0;
        wr(wsru_pkg::ADR_CMD, {9'h000, op});
        while (done !== 1'b1 && n < 64) begin
            @(posedge clk_i);
            n++;
        end
        check("done and busy", {30'h0, done, busy}, 32'h2);
    endtask : run
    // hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(wsru_pkg::ADR_FLAGS, 32'h0, "flags after reset");
        rc(8'h30, 32'h0, "unmapped read");
        $display("test reset finished");
        for (int i = 0; i < 6; i++) begin
            wr(wsru_pkg::ADR_FLAGS, s_fi[i]);
            wr(wsru_pkg::ADR_OPND, s_in[i]);
            run(s_op[i]);
            rc(wsru_pkg::ADR_OPND, {16'h0, s_rs[i]}, "result");
            rc(wsru_pkg::ADR_FLAGS, s_fo[i], "flags");
        end
        check("irq while masked", {31'h0, irq}, 32'h0);
        $display("test single-word finished");
        wr(wsru_pkg::ADR_RANGE, 16'h0100);
        wr(wsru_pkg::ADR_FLAGS, 16'h0000);
        wr(wa(0), 16'h8000);
        wr(wa(1), 16'h8001);
        wr(wsru_pkg::ADR_CTRL, 16'h6000);
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        rc(wa(0), 32'h0001, "left word0");
        rc(wa(1), 32'h0003, "left word1");
        rc(wsru_pkg::ADR_FLAGS, 32'h2, "left carry");
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        rc(wa(0), 32'h0001, "strobe held");
        wr(wsru_pkg::ADR_CTRL, 16'h0000);
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        wr(wsru_pkg::ADR_CTRL, 16'h5000);
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        rc(wa(0), 32'h8000, "right word0");
        rc(wa(1), 32'h0001, "right word1");
        rc(wsru_pkg::ADR_FLAGS, 32'h2, "right carry");
        wr(wsru_pkg::ADR_CTRL, 16'h0000);
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        wr(wsru_pkg::ADR_CTRL, 16'hF000);
        run(wsru_pkg::OP_REVERSIBLE_SHIFT_OP);
        rc(wa(0), 32'h0, "reset word0");
        rc(wa(1), 32'h0, "reset word1");
        rc(wsru_pkg::ADR_FLAGS, 32'h0, "reset carry");
        $display("test reversible finished");
        wr(wsru_pkg::ADR_RANGE, 16'h0200);
        wr(wa(0), 16'hAAAA);
        wr(wa(1), 16'hBBBB);
        wr(wa(2), 16'hCCCC);
        wr(wsru_pkg::ADR_SRC, 16'h1234);
        run(wsru_pkg::OP_WORD_SHIFT_OP);
        rc(wa(0), 32'h1234, "word shift w0");
        rc(wa(1), 32'hAAAA, "word shift w1");
        rc(wa(2), 32'hBBBB, "word shift w2");
        wr(wsru_pkg::ADR_RANGE, 16'h0100);
        run(wsru_pkg::OP_DIGL);
        rc(wa(0), 32'h2340, "digit left w0");
        rc(wa(1), 32'hAAA1, "digit left w1");
        run(wsru_pkg::OP_DIGR);
        rc(wa(0), 32'h1234, "digit right w0");
        rc(wa(1), 32'h0AAA, "digit right w1");
        wr(wsru_pkg::ADR_IMASK, 16'h0002);
        wr(wsru_pkg::ADR_RANGE, 16'h0102);
        run(wsru_pkg::OP_WORD_SHIFT_OP);
        rc(wsru_pkg::ADR_FLAGS, 32'h1, "range error");
        rc(wa(1), 32'h0AAA, "no change on error");
        rc(wsru_pkg::ADR_ISTAT, 32'h3, "status bits");
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(wsru_pkg::ADR_ISTAT, 16'h0002);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test multi-word finished");
        print_verdict();
    end
endmodule : test_word_shift_rotate_unit
`default_nettype wire
